// File: tdct_core_model.sv
// Purpose: Core memory partner on the memory data channel.
// Assumes: One request at a time, held until its ack.
// Notes: wait_in stretches each answer to model a busy memory.
`timescale 1ns/1ps
module tdct_core_model (
  // Clock
  input wire logic clk_in,
  // Channel
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [14:0] addr_in,
  input wire logic [17:0] wdata_in,
  input wire logic [7:0] wait_in,
  output logic [17:0] rdata_out,
  output logic ack_out
);
  logic [17:0] core [0:32767];
  logic [7:0] cnt;
  initial begin
    ack_out = 1'b0;
    rdata_out = 18'h2aaaa;
    cnt = 8'h00;
  end
  // Read data is only good with ack; otherwise the bus toggles.
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      if (cnt >= wait_in) begin
        cnt <= 8'h00;
        ack_out <= 1'b1;
        if (we_in) core[addr_in] <= wdata_in;
        else rdata_out <= core[addr_in];
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule

// File: tdct_fifo.sv
// Purpose: Word buffer between tape intake and the memory data channel.
// Assumes: DEPTH is a power of two.
// Notes: Flush empties the buffer in one cycle and wins over a push.
`timescale 1ns/1ps

module tdct_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic flush_in,
  // Stream
  tdct_stream_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(q.wdata) != WIDTH) begin : g_bad
      $error("tdct_fifo: depth must be a power of two and width must match");
    end
  endgenerate

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  wire empty = (wr_ptr == rd_ptr);
  wire full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  wire push = q.wvalid && !full;
  wire pop = q.rready && !empty;

  assign q.wready = !full;
  assign q.rvalid = !empty;
  assign q.rdata = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= q.wdata;
    end
  end
endmodule

// File: tdct_params.svh
// Purpose: Constants of the tape data channel transfer block.
// Assumes: An 18-bit word machine with core addresses in the low bits of a word.
// Notes: Times keep their printed unit; cycle counts are derived from the clock rate.
`ifndef TDCT_PARAMS_SVH
`define TDCT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Fixed core locations of the channel words
// ----------------------------------------------------------------------------
`define TDCT_WC_LOC 15'h0018
`define TDCT_CA_LOC 15'h0019

// ----------------------------------------------------------------------------
// Status register layout and reset value
// ----------------------------------------------------------------------------
`define TDCT_STATUS_RESET 18'h00000
`define TDCT_UNIT_HI 17
`define TDCT_UNIT_LO 15
`define TDCT_REV_BIT 14
`define TDCT_GO_BIT 13
`define TDCT_CONT_BIT 12
`define TDCT_FUNC_HI 11
`define TDCT_FUNC_LO 9
`define TDCT_IE_BIT 8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TDCT_CLK_MHZ 125
`define TDCT_WORD_PERIOD_US 200
`define TDCT_WORD_TOL_PCT 30
`define TDCT_STD_BLOCK_WORDS 256
`define TDCT_WORD_CYC (`TDCT_WORD_PERIOD_US * `TDCT_CLK_MHZ)
`define TDCT_WORD_MAX_CYC \
  ((`TDCT_WORD_PERIOD_US * (100 + `TDCT_WORD_TOL_PCT) * `TDCT_CLK_MHZ) / 100)
`define TDCT_TURN_CYC (`TDCT_STD_BLOCK_WORDS * `TDCT_WORD_CYC)

`endif

// File: tdct_pkg.sv
// Purpose: Types shared by the tape data channel transfer modules.
// Assumes: Nothing beyond the constants header.
// Notes: Function codes follow the three-bit function field.
package tdct_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_MOVE = 3'h0,
    FN_SEARCH = 3'h1,
    FN_READ_DATA = 3'h2,
    FN_READ_ALL = 3'h3,
    FN_WRITE_DATA = 3'h4,
    FN_WRITE_ALL = 3'h5,
    FN_WRITE_TIMING = 3'h6,
    FN_UNUSED = 3'h7
  } tdct_func_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_WC = 3'h1,
    ST_WR_WC = 3'h2,
    ST_RD_CA = 3'h3,
    ST_WR_CA = 3'h4,
    ST_XFER = 3'h5
  } tdct_state_t;

endpackage

// File: tdct_stream_if.sv
// Purpose: Valid/ready word stream between the transfer logic and its buffer.
// Assumes: One clock for both sides.
// Notes: A word moves on a cycle where valid and ready are both high.
`timescale 1ns/1ps

interface tdct_stream_if #(parameter int WIDTH = 18);
  logic [WIDTH-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  logic rready;

  modport fill (output wdata, output wvalid, input wready);
  modport drain (input rdata, input rvalid, output rready);
  modport fifo (input wdata, input wvalid, output wready,
                output rdata, output rvalid, input rready);
endinterface

// File: tdct_transfer.sv
// Purpose: Data channel transfer control of a block-formatted tape controller.
// Assumes: Memory answers each request with a one-cycle ack; tape strobes are synchronous.
// Notes: The channel words live in core, so every word costs five memory cycles.
`timescale 1ns/1ps
`include "tdct_params.svh"

module tdct_transfer
  import tdct_pkg::*;
#(
  parameter int WORD_W = 18,
  parameter int ADDR_W = 15,
  parameter int FIFO_DEPTH = 8,
  parameter int WORD_MAX_CYCLES = `TDCT_WORD_MAX_CYC,
  parameter int TURN_CYCLES = `TDCT_TURN_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Status commands from the processor
  input wire logic [WORD_W-1:0] acc_in,
  input wire logic load_status_command_in,
  input wire logic xor_status_command_in,
  output logic [WORD_W-1:0] status_out,
  // Tape read words
  input wire logic [WORD_W-1:0] tape_word_in,
  input wire logic tape_word_valid_in,
  output logic tape_word_ready_out,
  input wire logic tape_block_end_in,
  input wire logic [WORD_W-1:0] parity_check_character_in,
  // Tape write words
  output logic [WORD_W-1:0] tape_wr_word_out,
  output logic tape_wr_valid_out,
  input wire logic tape_wr_ready_in,
  output logic record_enable_out,
  // Memory data channel
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [WORD_W-1:0] mem_wdata_out,
  input wire logic [WORD_W-1:0] mem_rdata_in,
  input wire logic mem_ack_in,
  // Condition flags
  output logic wc_overflow_out,
  output logic parity_error_out,
  output logic timing_error_out,
  output logic up_to_speed_out
);
  localparam int TW = $clog2(TURN_CYCLES + 1);
  localparam int CW = $clog2(WORD_MAX_CYCLES + 1);

  generate
    if (WORD_W != 18 || ADDR_W > WORD_W || WORD_MAX_CYCLES < 1 || TURN_CYCLES < 8)
    begin : g_bad
      $error("tdct_transfer: unsupported parameter values");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [WORD_W-1:0] inc_word(input logic [WORD_W-1:0] w);
    inc_word = w + WORD_W'(1);
  endfunction

  function automatic logic [17:0] rev_groups(input logic [17:0] w);
    logic [17:0] r;
    r = '0;
    for (int i = 0; i < 6; i++) begin
      r[3*i +: 3] = w[3*(5-i) +: 3];
    end
    rev_groups = r;
  endfunction

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------------------
  logic [WORD_W-1:0] status;
  logic [WORD_W-1:0] next_status;

  // A full load wins over the exclusive-or when both arrive together.
  assign next_status = load_status_command_in ? acc_in :
                       xor_status_command_in ? (status ^ acc_in) : status;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      status <= `TDCT_STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  wire tdct_func_t func = tdct_func_t'(status[`TDCT_FUNC_HI:`TDCT_FUNC_LO]);
  wire go = status[`TDCT_GO_BIT];
  wire rev = status[`TDCT_REV_BIT];
  wire func_read = go && (func == FN_READ_DATA || func == FN_READ_ALL);
  wire func_write = go && (func == FN_WRITE_DATA || func == FN_WRITE_ALL);
  assign status_out = status;

  AST_LOAD: assert property (load_status_command_in |=> status == $past(acc_in))
    else $error("status load did not take the accumulator");
  AST_XOR: assert property (xor_status_command_in && !load_status_command_in
    |=> status == ($past(status) ^ $past(acc_in)))
    else $error("exclusive-or status command did not combine");

  // --------------------------------------------------------------------------
  // Turnaround settling
  // --------------------------------------------------------------------------
  logic prev_rev;
  logic prev_go;
  logic [TW-1:0] turn_cnt;

  // Direction flipped while run stayed set on both sides of the change.
  wire turnaround = go && prev_go && (rev != prev_rev);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prev_rev <= 1'b0;
      prev_go <= 1'b0;
      turn_cnt <= '0;
    end else begin
      prev_rev <= rev;
      prev_go <= go;
      if (turnaround) begin
        turn_cnt <= TW'(TURN_CYCLES);
      end else if (turn_cnt != '0) begin
        turn_cnt <= turn_cnt - TW'(1);
      end
    end
  end

  assign up_to_speed_out = (turn_cnt == '0);

  AST_TURN: assert property (turnaround |=> !up_to_speed_out [*8])
    else $error("tape reported at speed right after turnaround");

  // --------------------------------------------------------------------------
  // Tape intake and buffer
  // --------------------------------------------------------------------------
  logic wc_overflow;
  tdct_stream_if #(.WIDTH(WORD_W)) rd_q ();

  // Words arriving before the tape is at speed are missed, not stored.
  wire intake_open = func_read && up_to_speed_out && !wc_overflow;
  wire take_word = tape_word_valid_in && tape_word_ready_out;
  assign tape_word_ready_out = rd_q.wready && intake_open;
  assign rd_q.wvalid = tape_word_valid_in && intake_open;
  assign rd_q.wdata = rev ? rev_groups(tape_word_in) : tape_word_in;

  // Arrival order is kept, so a reversed block lands last word first.
  tdct_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .flush_in(load_status_command_in),
    .q(rd_q)
  );

  AST_NO_SLOW: assert property (!up_to_speed_out |-> !rd_q.wvalid)
    else $error("word taken before tape reached speed");
  AST_GROUPS: assert property (rd_q.wvalid && rev |-> rd_q.wdata[2:0] == tape_word_in[17:15]
    && rd_q.wdata[17:15] == tape_word_in[2:0] && rd_q.wdata[8:6] == tape_word_in[11:9])
    else $error("reverse word groups not swapped");

  // --------------------------------------------------------------------------
  // Channel sequencer
  // --------------------------------------------------------------------------
  tdct_state_t state;
  tdct_state_t next_state;
  logic xfer_wr;
  logic [ADDR_W-1:0] next_addr;
  logic [WORD_W-1:0] next_wdata;
  logic next_we;
  logic tape_wr_valid;

  wire start_rd = rd_q.rvalid && !wc_overflow;
  wire start_wr = func_write && !wc_overflow && !tape_wr_valid && up_to_speed_out;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_rd || start_wr) begin
          next_state = ST_RD_WC;
        end
      end
      ST_RD_WC: if (mem_ack_in) next_state = ST_WR_WC;
      ST_WR_WC: if (mem_ack_in) next_state = ST_RD_CA;
      ST_RD_CA: if (mem_ack_in) next_state = ST_WR_CA;
      ST_WR_CA: if (mem_ack_in) next_state = ST_XFER;
      ST_XFER: if (mem_ack_in) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Count word first, then the pointer is pre-incremented and used at once.
  assign next_addr = (next_state == ST_RD_WC || next_state == ST_WR_WC) ? `TDCT_WC_LOC :
                     (next_state == ST_XFER) ? mem_wdata_out[ADDR_W-1:0] :
                     `TDCT_CA_LOC;
  assign next_wdata = (next_state == ST_XFER) ? rd_q.rdata :
                      inc_word(mem_rdata_in);
  assign next_we = (next_state == ST_WR_WC || next_state == ST_WR_CA) ||
                   (next_state == ST_XFER && !xfer_wr);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      xfer_wr <= 1'b0;
      mem_addr_out <= '0;
      mem_wdata_out <= '0;
      mem_we_out <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_RD_WC) begin
        xfer_wr <= !start_rd;
      end
      if (next_state != state) begin
        mem_addr_out <= next_addr;
        mem_wdata_out <= next_wdata;
        mem_we_out <= next_we;
      end
    end
  end

  assign mem_req_out = (state != ST_IDLE);
  assign rd_q.rready = (state == ST_XFER) && mem_ack_in && !xfer_wr;

  sequence s_ptr_to_count;
    state == ST_WR_CA && mem_ack_in && !xfer_wr &&
      mem_wdata_out[ADDR_W-1:0] == `TDCT_WC_LOC;
  endsequence
  sequence s_ptr_to_self;
    state == ST_WR_CA && mem_ack_in && mem_wdata_out[ADDR_W-1:0] == `TDCT_CA_LOC;
  endsequence

  AST_WC_ADDR: assert property (state inside {ST_RD_WC, ST_WR_WC} |-> mem_addr_out ==
    `TDCT_WC_LOC)
    else $error("count word not taken from its core location");
  AST_CA_ADDR: assert property (state inside {ST_RD_CA, ST_WR_CA} |-> mem_addr_out ==
    `TDCT_CA_LOC)
    else $error("address word not taken from its core location");
  AST_DATA_ADDR: assert property (state == ST_WR_CA && mem_ack_in |=>
    state == ST_XFER && mem_addr_out == $past(mem_wdata_out[ADDR_W-1:0]))
    else $error("data word not placed at the incremented pointer");
  AST_LINK_COUNT: assert property (s_ptr_to_count |-> ##1 (state == ST_XFER &&
    mem_addr_out == `TDCT_WC_LOC && mem_we_out))
    else $error("linked load did not store first word as the count");
  AST_LINK_SELF: assert property (s_ptr_to_self |-> ##1 (state == ST_XFER &&
    mem_addr_out == `TDCT_CA_LOC))
    else $error("linked load did not store second word as the pointer");
  AST_WC_INC: assert property (state == ST_RD_WC && mem_ack_in |=>
    mem_wdata_out == $past(mem_rdata_in) + 18'h00001)
    else $error("count word not incremented by one");

  // --------------------------------------------------------------------------
  // Count overflow and tape write word
  // --------------------------------------------------------------------------
  wire wc_wrap = (state == ST_WR_WC) && mem_ack_in && (mem_wdata_out == '0);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wc_overflow <= 1'b0;
      tape_wr_valid <= 1'b0;
      tape_wr_word_out <= '0;
    end else begin
      if (wc_wrap) begin
        wc_overflow <= 1'b1;
      end else if (load_status_command_in) begin
        wc_overflow <= 1'b0;
      end
      if (state == ST_XFER && mem_ack_in && xfer_wr) begin
        tape_wr_valid <= 1'b1;
        tape_wr_word_out <= mem_rdata_in;
      end else if (tape_wr_ready_in) begin
        tape_wr_valid <= 1'b0;
      end
    end
  end

  assign wc_overflow_out = wc_overflow;
  assign tape_wr_valid_out = tape_wr_valid;
  // The word fetched with the overflowing count is still recorded, then writing stops.
  assign record_enable_out = func_write && (!wc_overflow || tape_wr_valid);

  AST_OVF_STOP: assert property (wc_overflow && state == ST_IDLE |=> state == ST_IDLE)
    else $error("channel transfer started after count overflow");
  AST_REC_STOP: assert property (state == ST_IDLE && wc_overflow && !tape_wr_valid &&
    !load_status_command_in |=> !record_enable_out
    && !tape_wr_valid_out)
    else $error("recording continued after count overflow");

  // --------------------------------------------------------------------------
  // Parity check character
  // --------------------------------------------------------------------------
  logic [WORD_W-1:0] pcc_acc;
  logic [WORD_W-1:0] pair_hold;
  logic pair_odd;

  wire read_data_fn = go && (func == FN_READ_DATA);
  // Words fold in pairs; an odd last word is never folded in, hence the false error.
  wire pcc_bad = pair_odd || (pcc_acc != parity_check_character_in);
  wire parity_set = tape_block_end_in && read_data_fn && pcc_bad;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pcc_acc <= '0;
      pair_hold <= '0;
      pair_odd <= 1'b0;
      parity_error_out <= 1'b0;
    end else begin
      if (tape_block_end_in) begin
        pcc_acc <= '0;
        pair_odd <= 1'b0;
      end else if (take_word && read_data_fn) begin
        pair_odd <= !pair_odd;
        pair_hold <= tape_word_in;
        if (pair_odd) begin
          pcc_acc <= pcc_acc ^ pair_hold ^ tape_word_in;
        end
      end
      if (parity_set) begin
        parity_error_out <= 1'b1;
      end else if (load_status_command_in) begin
        parity_error_out <= 1'b0;
      end
    end
  end

  AST_PARITY_FN: assert property ($rose(parity_error_out) |-> $past(read_data_fn)
    && $past(tape_block_end_in))
    else $error("parity error raised outside read-data block end");

  // --------------------------------------------------------------------------
  // Word service time
  // --------------------------------------------------------------------------
  logic [CW-1:0] wait_cnt;

  wire req_pending = start_rd || start_wr || (state != ST_IDLE);
  wire served = (state == ST_XFER) && mem_ack_in;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= '0;
      timing_error_out <= 1'b0;
    end else begin
      if (served || !req_pending) begin
        wait_cnt <= '0;
      end else if (wait_cnt != CW'(WORD_MAX_CYCLES)) begin
        wait_cnt <= wait_cnt + CW'(1);
      end
      if (req_pending && !served && wait_cnt == CW'(WORD_MAX_CYCLES)) begin
        timing_error_out <= 1'b1;
      end else if (load_status_command_in) begin
        timing_error_out <= 1'b0;
      end
    end
  end

  AST_TIMING: assert property ($rose(timing_error_out) |-> $past(wait_cnt) ==
    CW'(WORD_MAX_CYCLES))
    else $error("timing error raised before the word interval ran out");

  AST_OVF_SET: assert property (wc_wrap |=> wc_overflow_out)
    else $error("count wrap did not raise overflow");
endmodule

// File: tdct_transfer_tb.sv
// Purpose: Self-checking bench of the tape data channel transfer block.
// Assumes: Core model answers the channel; the bench plays tape and processor.
// Notes: Turnaround settling is shortened through TURN_CYCLES.
`timescale 1ns/1ps
module tdct_transfer_tb;
  import tdct_pkg::*;
  localparam int TURN = 20;
  logic clk_in, reset_n_in, ld, xr, twv, blk, wrr, rdy, twr_v, rec;
  logic req, we, ack, ovf, perr, spd, terr;
  logic [17:0] acc, tw, st, twr, rd, wd, parity_check_character;
  logic [14:0] addr;
  logic [7:0] mwait;
  int fails, n_checks, stalls;
  tdct_transfer #(.WORD_MAX_CYCLES(60), .TURN_CYCLES(TURN)) uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .acc_in(acc), .load_status_command_in(ld), .xor_status_command_in(xr),
    .status_out(st),
    .tape_word_in(tw), .tape_word_valid_in(twv), .tape_word_ready_out(rdy),
    .tape_block_end_in(blk), .parity_check_character_in(parity_check_character),
    .tape_wr_word_out(twr), .tape_wr_valid_out(twr_v), .tape_wr_ready_in(wrr),
    .record_enable_out(rec),
    .mem_req_out(req), .mem_we_out(we), .mem_addr_out(addr), .mem_wdata_out(wd),
    .mem_rdata_in(rd), .mem_ack_in(ack),
    .wc_overflow_out(ovf), .parity_error_out(perr), .timing_error_out(terr),
    .up_to_speed_out(spd)
  );
  tdct_core_model m (.clk_in(clk_in), .req_in(req), .we_in(we), .addr_in(addr),
    .wdata_in(wd), .wait_in(mwait), .rdata_out(rd), .ack_out(ack));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task hang;
    chk(18'h0, 18'h1);
    tally_and_finish();
  endtask
  function automatic logic [17:0] rev(input logic [17:0] w);
    for (int g = 0; g < 6; g++) rev[3*g+:3] = w[15-3*g+:3];
  endfunction
  function automatic logic [17:0] wv(input int i);
    wv = 18'h0a72e + 18'h01041 * i[17:0];
  endfunction
  task cmd(input logic load, input logic [17:0] v);
    @(negedge clk_in);
    acc = v;
    ld = load;
    xr = !load;
    @(negedge clk_in);
    ld = 1'b0;
    xr = 1'b0;
  endtask
  // Valid stays up between words so that no edge sees a double assignment.
  task send(input logic [17:0] w);
    int i;
    tw = w;
    twv = 1'b1;
    for (i = 0; i < 999 && rdy !== 1'b1; i++) begin
      stalls++;
      @(negedge clk_in);
    end
    if (i == 999) hang();
    @(negedge clk_in);
  endtask
  task settle;
    int i, q;
    twv = 1'b0;
    tw = ~tw;
    q = 0;
    for (i = 0; i < 4000 && q < 4; i++) begin
      @(negedge clk_in);
      q = req ? 0 : q + 1;
    end
    if (q < 4) hang();
  endtask
  task pulse_end;
    blk = 1'b1;
    @(negedge clk_in);
    blk = 1'b0;
    @(negedge clk_in);
  endtask
  task t_status;
    cmd(1'b1, 18'h0c0ff);
    cmd(1'b0, 18'h00600);
    chk(st, 18'h0c6ff);
    $display("status test done");
  endtask
  task t_boot;
    mwait = 8'h00;
    m.core[15'h0018] = 18'h00000;
    m.core[15'h0019] = 18'h00017;
    cmd(1'b1, 18'h1b500);
    chk(st, 18'h1b500);
    chk({17'h0, rdy}, 18'h1);
    send(18'h3fffc);
    send(18'h001ff);
    for (int i = 0; i < 3; i++) send(18'h12340 + i[17:0]);
    settle();
    for (int i = 0; i < 3; i++) chk(m.core[15'h0200 + i[14:0]], 18'h12340 + i[17:0]);
    chk(m.core[15'h0018], 18'h00000);
    chk(m.core[15'h0019], 18'h00202);
    chk({17'h0, ovf}, 18'h1);
    twv = 1'b1;
    @(negedge clk_in);
    chk({17'h0, rdy}, 18'h0);
    twv = 1'b0;
    pulse_end();
    chk({17'h0, perr}, 18'h1);
    $display("linked load test done");
  endtask
  task t_reverse;
    int n;
    mwait = 8'h06;
    m.core[15'h0018] = 18'h3fff6;
    m.core[15'h0019] = 18'h003ff;
    cmd(1'b1, 18'h1f500);
    chk({17'h0, ovf}, 18'h0);
    @(negedge clk_in);
    chk({17'h0, spd}, 18'h0);
    n = 0;
    while (spd !== 1'b1 && n < 999) begin
      if (rdy !== 1'b0) chk({17'h0, rdy}, 18'h0);
      n++;
      @(negedge clk_in);
    end
    chk({17'h0, n > TURN - 4 && n < TURN + 3}, 18'h1);
    stalls = 0;
    for (int i = 0; i < 10; i++) send(wv(i));
    chk({17'h0, stalls > 0}, 18'h1);
    settle();
    for (int i = 0; i < 10; i++) chk(m.core[15'h0400 + i[14:0]], rev(wv(i)));
    parity_check_character = 18'h00000;
    for (int i = 0; i < 10; i++) parity_check_character = parity_check_character ^ wv(i);
    pulse_end();
    chk({17'h0, perr}, 18'h0);
    pulse_end();
    chk({17'h0, perr}, 18'h1);
    chk({17'h0, terr}, 18'h0);
    chk({17'h0, ovf}, 18'h1);
    $display("reverse test done");
  endtask
  task t_write;
    int i, extra;
    mwait = 8'h0f;
    cmd(1'b1, 18'h00000);
    m.core[15'h0018] = 18'h3fffe;
    m.core[15'h0019] = 18'h002ff;
    m.core[15'h0300] = 18'h15555;
    m.core[15'h0301] = 18'h0aaaa;
    m.core[15'h0302] = 18'h33333;
    cmd(1'b1, 18'h1b900);
    chk({17'h0, rec}, 18'h1);
    for (int k = 0; k < 2; k++) begin
      for (i = 0; i < 999 && twr_v !== 1'b1; i++) @(negedge clk_in);
      if (i == 999) hang();
      repeat (3) @(negedge clk_in);
      chk(twr, k ? 18'h0aaaa : 18'h15555);
      wrr = 1'b1;
      @(negedge clk_in);
      wrr = 1'b0;
    end
    extra = 0;
    repeat (100) begin
      @(negedge clk_in);
      if (twr_v !== 1'b0) extra++;
    end
    chk(extra[17:0], 18'h0);
    chk({17'h0, rec}, 18'h0);
    pulse_end();
    chk({17'h0, perr}, 18'h0);
    chk({17'h0, terr}, 18'h1);
    $display("write test done");
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    reset_n_in = 1'b0;
    {ld, xr, twv, blk, wrr} = 5'h00;
    acc = 18'h00000;
    tw = 18'h00000;
    parity_check_character = 18'h00000;
    mwait = 8'h00;
    fails = 0;
    n_checks = 0;
    stalls = 0;
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_status();
    t_boot();
    t_reverse();
    t_write();
    tally_and_finish();
  end
endmodule
